// File: i2m_consts.svh
// i2m_consts.svh: register offsets, field positions and timing counts
// assumes: included by every i2m design file that needs a number
`ifndef I2M_CONSTS_SVH
`define I2M_CONSTS_SVH
`define I2M_A_CFG     3'h0
`define I2M_A_ADR     3'h1
`define I2M_A_STAT    3'h2
`define I2M_A_MASK    3'h3
`define I2M_A_TXD     3'h4
`define I2M_A_RXD     3'h5
`define I2M_A_MODE    3'h6
`define I2M_CNT_MSB   4
`define I2M_CNT_LSB   0
`define I2M_RATE_MSB  6
`define I2M_RATE_LSB  5
`define I2M_CFG_EN    7
`define I2M_MODE_FULL 0
`define I2M_RW_BIT    0
`define I2M_B_NOACK   6
`define I2M_B_RXIRQ   5
`define I2M_B_TXIRQ   4
`define I2M_B_TXOVF   0
`define I2M_QTR_BASE  8'h04
`define I2M_PH_SET    2'h0
`define I2M_PH_RISE   2'h1
`define I2M_PH_HIGH   2'h2
`define I2M_PH_LAST   2'h3
`define I2M_BIT_LAST  3'h7
`define I2M_FS_EMPTY  2'h0
`define I2M_FS_HALF   2'h2
`define I2M_FS_FULL   2'h3
`endif

// File: i2m_pkg.sv
// i2m_pkg.sv: types shared by the i2m master engine
// assumes: compiled before every other i2m file
package i2m_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_BYTE  = 3'h3,
    ST_ACK   = 3'h2,
    ST_STOP  = 3'h6
  } i2m_state_t;
  typedef logic [7:0] i2m_byte_t;
endpackage : i2m_pkg

// File: i2m_fifo_if.sv
// i2m_fifo_if.sv: push/pop carrier between the engine and one byte FIFO
// assumes: all signals on the engine clock
`timescale 1ns/1ps
interface i2m_fifo_if
  import i2m_pkg::*;
#(
  parameter int CW = 3
);
  logic          push;
  i2m_byte_t     wdata;
  logic          pop;
  i2m_byte_t     rdata;
  logic          flush;
  logic          full;
  logic          empty;
  logic [CW-1:0] count;
  modport user  (output push, wdata, pop, flush, input rdata, full, empty, count);
  modport store (input push, wdata, pop, flush, output rdata, full, empty, count);
endinterface : i2m_fifo_if

// File: i2m_sync.sv
// i2m_sync.sv: two-flop synchroniser for pad inputs
// assumes: inputs asynchronous to clk, q read by logic only
`timescale 1ns/1ps
module i2m_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  if (W < 1) begin : g_chk
    $error("i2m_sync: W must be at least 1");
  end

  // idle bus level is high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '1;
      q      <= '1;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : i2m_sync

// File: i2m_fifo.sv
// i2m_fifo.sv: byte FIFO, first in first out, refuses push when full
// assumes: pop ignored when empty, flush empties in one cycle
`timescale 1ns/1ps
module i2m_fifo
  import i2m_pkg::*;
#(
  parameter int DEPTH = 4
) (
  input  wire logic  clk,
  input  wire logic  rst_b,
  i2m_fifo_if.store  f
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULLCNT = (AW+1)'(DEPTH);

  i2m_byte_t     mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0]   cnt_r;
  logic          doPush;
  logic          doPop;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("i2m_fifo: DEPTH must be a power of two, at least 2");
  end

  assign doPush  = f.push && !f.full;
  assign doPop   = f.pop && !f.empty;
  assign f.full  = cnt_r == FULLCNT;
  assign f.empty = cnt_r == '0;
  assign f.count = cnt_r;
  assign f.rdata = mem[rdPtr_r];

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_r] <= f.wdata;
    end
  end

  // pointers walk in load order
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r   <= '0;
    end else if (f.flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r   <= '0;
    end else begin
      if (doPush) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (doPop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      unique case ({doPush, doPop})
        2'b10:   cnt_r <= cnt_r + 1'b1;
        2'b01:   cnt_r <= cnt_r - 1'b1;
        default: cnt_r <= cnt_r;
      endcase
    end
  end
endmodule : i2m_fifo

// File: i2m_master.sv
// i2m_master.sv: I2C master engine with byte FIFOs and register port
// assumes: one clock, open-drain pads resolved outside, pad inputs async
// Overview of operation
// - address register bit 0 picks read or write for the transaction.
// - on reads the engine drives master ACK itself after each byte before the receive count is reached.
// - engine sends NACK itself on the byte reaching the receive count.
// - address rewritten mid-transfer gives repeated START instead of STOP.
// - separate four-byte receive FIFO and four-byte transmit FIFO.
// - up to four preloaded tx bytes go out in load order.
// - tx FIFO going empty sets tx interrupt flag, requests interrupt if enabled.
// - tx FIFO empty when next byte is needed ends the transfer.
// - errors such as missing slave ACK end reads and writes.
// - an error during a write flushes the tx FIFO.
// - four received bytes held unread; software must drain in time.
// - receive interrupt per byte or only when rx FIFO fills.
// - read stops when received byte count equals receive count field.
// - address write starts a transaction; bits 7..1 address, bit 0 read.
// - missing ACK sets a sticky flag and stops the transfer.
// - writing tx data while tx FIFO full sets overflow error.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "i2m_consts.svh"
module i2m_master
  import i2m_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  output logic            irq,
  input  wire logic       sclIn,
  output logic            sclOut,
  output logic            sclOe,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe
);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  i2m_state_t state_r;
  logic [1:0] phase_r;
  logic [7:0] qCnt_r;
  logic [2:0] bitCnt_r;
  i2m_byte_t  shift_r;
  logic       rdMode_r;
  logic       addrPhase_r;
  logic [4:0] rxNum_r;
  logic       ackSmp_r;
  i2m_byte_t  cfg_r;
  i2m_byte_t  adr_r;
  i2m_byte_t  mask_r;
  logic       mode_r;
  logic       pend_r;
  logic       noAck_r;
  logic       rxIrq_r;
  logic       txIrq_r;
  logic       txOvf_r;
  logic       txEmptyD_r;
  logic       rxFullD_r;
  logic       irq_r;
  i2m_byte_t  rdata_r;
  logic       sclOe_r;
  logic       sdaOe_r;
  logic       lowDrive_r;
  logic [1:0] pinS;
  logic       sclS;
  logic       sdaS;
  logic [7:0] qtrLoad;
  logic       tick;
  logic       step;
  logic       phSet;
  logic       phRise;
  logic       phHigh;
  logic       phLast;
  logic       busy;
  logic       masterAcks;
  logic       lastByte;
  logic       slaveNak;
  logic       ackEnd;
  logic       endXfer;
  logic       rxDone;
  logic       popTx;
  logic       wrAdr;
  logic       wrStat;
  logic       wrTxd;
  logic       rdRxd;
  logic [1:0] fifoStat;
  i2m_byte_t  sticky;
  i2m_byte_t  statRd;

  i2m_fifo_if #(.CW(CW)) txf ();
  i2m_fifo_if #(.CW(CW)) rxf ();

  //////////////////////////////////////////////////////////////////////////////
  // submodules

  i2m_fifo #(.DEPTH(FIFO_DEPTH)) u_txf (
    .clk   (clk),
    .rst_b (rst_b),
    .f     (txf.store)
  );

  i2m_fifo #(.DEPTH(FIFO_DEPTH)) u_rxf (
    .clk   (clk),
    .rst_b (rst_b),
    .f     (rxf.store)
  );

  i2m_sync #(.W(2)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({sdaIn, sclIn}),
    .q     (pinS)
  );

  //////////////////////////////////////////////////////////////////////////////
  // decode and sequencing terms

  assign sclS       = pinS[0];
  assign sdaS       = pinS[1];
  assign wrAdr      = regWr && regAddr == `I2M_A_ADR;
  assign wrStat     = regWr && regAddr == `I2M_A_STAT;
  assign wrTxd      = regWr && regAddr == `I2M_A_TXD;
  assign rdRxd      = regRd && regAddr == `I2M_A_RXD;
  assign qtrLoad    = (`I2M_QTR_BASE << cfg_r[`I2M_RATE_MSB:`I2M_RATE_LSB]) - 8'h01;
  assign tick       = qCnt_r == 8'h00;
  // slave may stretch: high phase waits for the sampled clock
  assign step       = tick && !(phase_r == `I2M_PH_HIGH && !sclS);
  assign phSet      = step && phase_r == `I2M_PH_SET;
  assign phRise     = step && phase_r == `I2M_PH_RISE;
  assign phHigh     = step && phase_r == `I2M_PH_HIGH;
  assign phLast     = step && phase_r == `I2M_PH_LAST;
  assign busy       = state_r != ST_IDLE;
  assign masterAcks = rdMode_r && !addrPhase_r;
  assign lastByte   = rxNum_r >= cfg_r[`I2M_CNT_MSB:`I2M_CNT_LSB];
  assign slaveNak   = !masterAcks && ackSmp_r;
  assign ackEnd     = state_r == ST_ACK && phLast;
  // nak, count reached, or tx data missing
  assign endXfer    = slaveNak || (masterAcks && lastByte) || (!rdMode_r && txf.empty);
  assign rxDone     = state_r == ST_BYTE && phLast && bitCnt_r == `I2M_BIT_LAST
                      && rdMode_r && !addrPhase_r;
  assign popTx      = ackEnd && !endXfer && !rdMode_r;

  assign txf.push   = wrTxd;
  assign txf.wdata  = regWdata;
  assign txf.pop    = popTx;
  assign txf.flush  = ackEnd && slaveNak && !rdMode_r;
  assign rxf.push   = rxDone;
  assign rxf.wdata  = shift_r;
  assign rxf.pop    = rdRxd;
  assign rxf.flush  = 1'b0;

  assign fifoStat = (rdMode_r && busy) ?
                    (rxf.empty ? `I2M_FS_EMPTY : rxf.full ? `I2M_FS_FULL : `I2M_FS_HALF) :
                    (txf.empty ? `I2M_FS_EMPTY : txf.full ? `I2M_FS_FULL : `I2M_FS_HALF);
  assign sticky   = {1'b0, noAck_r, rxIrq_r, txIrq_r, 3'h0, txOvf_r};
  assign statRd   = {busy, noAck_r, rxIrq_r, txIrq_r, fifoStat, 1'b0, txOvf_r};

  assign regRdata = rdata_r;
  assign irq      = irq_r;
  assign sclOe    = sclOe_r;
  assign sdaOe    = sdaOe_r;
  assign sclOut   = lowDrive_r;
  assign sdaOut   = lowDrive_r;

  //////////////////////////////////////////////////////////////////////////////
  // bit timing

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      qCnt_r <= 8'h00;
    end else if (!busy || tick) begin
      qCnt_r <= qtrLoad;
    end else begin
      qCnt_r <= qCnt_r - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= `I2M_PH_SET;
    end else if (!busy) begin
      phase_r <= `I2M_PH_SET;
    end else if (step) begin
      phase_r <= phase_r + 2'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transaction sequencer

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r  <= ST_IDLE;
      bitCnt_r <= 3'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (pend_r && cfg_r[`I2M_CFG_EN]) begin
            state_r <= ST_START;
          end
        end
        ST_START: begin
          if (phLast) begin
            state_r  <= ST_BYTE;
            bitCnt_r <= 3'h0;
          end
        end
        ST_BYTE: begin
          if (phLast) begin
            bitCnt_r <= bitCnt_r + 3'h1;
            if (bitCnt_r == `I2M_BIT_LAST) begin
              state_r <= ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (ackEnd) begin
            // new address pending: repeated start, else stop
            state_r <= !endXfer ? ST_BYTE : (pend_r ? ST_START : ST_STOP);
          end
        end
        ST_STOP: begin
          if (phLast) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_r     <= 8'h00;
      rdMode_r    <= 1'b0;
      addrPhase_r <= 1'b0;
      rxNum_r     <= 5'h00;
      ackSmp_r    <= 1'b0;
    end else begin
      if (state_r == ST_START && phLast) begin
        shift_r     <= adr_r;
        rdMode_r    <= adr_r[`I2M_RW_BIT];
        addrPhase_r <= 1'b1;
        rxNum_r     <= 5'h00;
      end
      if (state_r == ST_BYTE && phHigh) begin
        shift_r <= {shift_r[6:0], sdaS};
      end
      if (rxDone) begin
        rxNum_r <= rxNum_r + 5'h01;
      end
      if (state_r == ST_ACK && phHigh) begin
        ackSmp_r <= sdaS;
      end
      if (ackEnd) begin
        addrPhase_r <= 1'b0;
      end
      if (popTx) begin
        shift_r <= txf.rdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus lines: enable high pulls the line low

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclOe_r    <= 1'b0;
      lowDrive_r <= 1'b0;
    end else if (phRise) begin
      sclOe_r <= 1'b0;
    end else if (phLast && state_r != ST_STOP && busy) begin
      sclOe_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sdaOe_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: sdaOe_r <= 1'b0;
        ST_START: begin
          if (phSet) begin
            sdaOe_r <= 1'b0;
          end else if (phHigh) begin
            sdaOe_r <= 1'b1;
          end
        end
        ST_BYTE: begin
          if (phSet) begin
            sdaOe_r <= !masterAcks && !shift_r[7];
          end
        end
        ST_ACK: begin
          if (phSet) begin
            sdaOe_r <= masterAcks && !lastByte;
          end
        end
        ST_STOP: begin
          if (phSet) begin
            sdaOe_r <= 1'b1;
          end else if (phLast) begin
            sdaOe_r <= 1'b0;
          end
        end
        default: sdaOe_r <= 1'b0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r  <= 8'h00;
      adr_r  <= 8'h00;
      mask_r <= 8'h00;
      mode_r <= 1'b0;
    end else if (regWr) begin
      unique case (regAddr)
        `I2M_A_CFG:  cfg_r  <= regWdata;
        `I2M_A_ADR:  adr_r  <= regWdata;
        `I2M_A_MASK: mask_r <= regWdata;
        `I2M_A_MODE: mode_r <= regWdata[`I2M_MODE_FULL];
        default:     mode_r <= mode_r;
      endcase
    end
  end

  // address write wins over the start that consumes it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_r <= 1'b0;
    end else if (wrAdr) begin
      pend_r <= 1'b1;
    end else if (state_r == ST_START && phLast) begin
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      noAck_r    <= 1'b0;
      rxIrq_r    <= 1'b0;
      txIrq_r    <= 1'b0;
      txOvf_r    <= 1'b0;
      txEmptyD_r <= 1'b1;
      rxFullD_r  <= 1'b0;
    end else begin
      txEmptyD_r <= txf.empty;
      rxFullD_r  <= rxf.full;
      if (ackEnd && slaveNak) begin
        noAck_r <= 1'b1;
      end else if (wrStat && regWdata[`I2M_B_NOACK]) begin
        noAck_r <= 1'b0;
      end
      if (mode_r ? (rxf.full && !rxFullD_r) : rxDone) begin
        rxIrq_r <= 1'b1;
      end else if ((wrStat && regWdata[`I2M_B_RXIRQ]) || (rdRxd && rxf.count == CW'(1))) begin
        rxIrq_r <= 1'b0;
      end
      if (txf.empty && !txEmptyD_r) begin
        txIrq_r <= 1'b1;
      end else if ((wrStat && regWdata[`I2M_B_TXIRQ]) || wrTxd) begin
        txIrq_r <= 1'b0;
      end
      if (wrTxd && txf.full) begin
        txOvf_r <= 1'b1;
      end else if (wrStat && regWdata[`I2M_B_TXOVF]) begin
        txOvf_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(sticky & mask_r);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        `I2M_A_CFG:  rdata_r <= cfg_r;
        `I2M_A_ADR:  rdata_r <= adr_r;
        `I2M_A_STAT: rdata_r <= statRd;
        `I2M_A_MASK: rdata_r <= mask_r;
        `I2M_A_RXD:  rdata_r <= rxf.rdata;
        `I2M_A_MODE: rdata_r <= {7'h00, mode_r};
        default:     rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_ackEnd;
    ackEnd;
  endsequence

  sequence s_txNak;
    s_ackEnd ##0 (slaveNak && !rdMode_r);
  endsequence

  property p_rw;
    (state_r == ST_START && phLast) |=> (rdMode_r == $past(adr_r[`I2M_RW_BIT]));
  endproperty
  a_rw: assert property (p_rw) else $error("rw bit not taken");

  property p_mack;
    (state_r == ST_ACK && phSet && masterAcks && !lastByte) |=> sdaOe_r;
  endproperty
  a_mack: assert property (p_mack) else $error("master ack missing");

  property p_mnak;
    (state_r == ST_ACK && phSet && masterAcks && lastByte) |=> !sdaOe_r;
  endproperty
  a_mnak: assert property (p_mnak) else $error("final nack missing");

  property p_rpt;
    s_ackEnd ##0 (endXfer && pend_r) |=> state_r == ST_START;
  endproperty
  a_rpt: assert property (p_rpt) else $error("no repeated start");

  property p_stop;
    s_ackEnd ##0 (endXfer && !pend_r) |=> state_r == ST_STOP;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop");

  property p_txIrq;
    $rose(txf.empty) |=> txIrq_r;
  endproperty
  a_txIrq: assert property (p_txIrq) else $error("tx flag not set");

  property p_txGone;
    s_ackEnd ##0 (!rdMode_r && txf.empty) |=> state_r != ST_BYTE;
  endproperty
  a_txGone: assert property (p_txGone) else $error("ran on empty fifo");

  property p_nak;
    s_txNak |=> (noAck_r && state_r != ST_BYTE);
  endproperty
  a_nak: assert property (p_nak) else $error("nak not handled");

  property p_flush;
    s_txNak |=> txf.empty;
  endproperty
  a_flush: assert property (p_flush) else $error("tx not flushed");

  property p_rxIrq;
    (rxDone && !mode_r) |=> rxIrq_r;
  endproperty
  a_rxIrq: assert property (p_rxIrq) else $error("rx flag not set");

  property p_cnt;
    s_ackEnd ##0 (masterAcks && lastByte) |=> state_r inside {ST_STOP, ST_START};
  endproperty
  a_cnt: assert property (p_cnt) else $error("read ran past count");

  property p_start;
    (wrAdr && cfg_r[`I2M_CFG_EN] && !busy) |=> pend_r ##1 state_r == ST_START;
  endproperty
  a_start: assert property (p_start) else $error("address write did not start");

  property p_ovf;
    (wrTxd && txf.full) |=> txOvf_r;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged");
endmodule : i2m_master

// File: i2m_slave_model.sv
// i2m_slave_model.sv: behavioural I2C target on the resolved pad wires
// assumes: pulled-up open-drain lines, outputs are pull-low enables
`timescale 1ns/1ps
module i2m_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ackOn,
  input  wire logic       slow,
  input  wire logic [7:0] rdBase,
  output logic            sclOe,
  output logic            sdaOe
);
  logic [7:0] sh;
  logic [7:0] got [0:63];
  logic       acks [0:63];
  logic [7:0] rdByte;
  int         nGot = 0;
  int         nAck = 0;
  int         nStart = 0;
  int         nStop = 0;
  int         bitIdx;
  logic       act, first, rdMode, done;
  assign rdByte = rdBase + 8'(nAck);
  initial begin
    sclOe = 1'b0;
    sdaOe = 1'b0;
    act = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    first = 1'b1;
    rdMode = 1'b0;
    done = 1'b0;
    bitIdx = -1;
    nStart++;
  end
  always @(posedge sda) if (scl && act) begin
    act = 1'b0;
    sdaOe = 1'b0;
    nStop++;
  end
  always @(posedge scl) if (act) begin
    if (bitIdx < 8 && !rdMode) sh = {sh[6:0], sda};
    if (bitIdx == 8) begin
      if (rdMode && !first) begin
        acks[nAck] = sda;
        nAck++;
        done = sda;
      end
      first = 1'b0;
    end
  end
  always @(negedge scl) if (act) begin
    bitIdx = (bitIdx == 8) ? 0 : bitIdx + 1;
    if (bitIdx == 8 && (first || !rdMode)) begin
      if (first) rdMode = sh[0];
      got[nGot] = sh;
      nGot++;
      sdaOe = ackOn;
    end else begin
      sdaOe = rdMode && !first && !done && bitIdx < 8 && !rdByte[7-bitIdx];
    end
  end
  // slow mode holds the clock low after each falling edge
  always @(negedge scl) if (act && slow) begin
    sclOe = 1'b1;
    #40;
    sclOe = 1'b0;
  end
endmodule : i2m_slave_model

// File: i2m_master_tb.sv
// i2m_master_tb.sv: register-level bench for the I2C master engine
// assumes: slave model on pulled-up pads, rate 0 quarter timing except the second read pass at rate 1
`timescale 1ns/1ps
`include "i2m_consts.svh"
module i2m_master_tb;
  logic       clk, rst_b, regWr, regRd, ackOn, slow, md;
  logic [2:0] regAddr;
  logic [7:0] regWdata, regRdata, rdBase, v, cn;
  logic       irq, sclOe, sdaOe, sSclOe, sSdaOe, sclO, sdaO;
  wire        sclW = !(sclOe || sSclOe);
  wire        sdaW = !(sdaOe || sSdaOe);
  int         fails, checks, n0, a0, s0, p0;
  i2m_master u_i2m_master (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq), .sclIn(sclW),
    .sclOut(sclO), .sclOe(sclOe), .sdaIn(sdaW), .sdaOut(sdaO), .sdaOe(sdaOe));
  i2m_slave_model u_slave (.scl(sclW), .sda(sdaW), .ackOn(ackOn), .slow(slow),
    .rdBase(rdBase), .sclOe(sSclOe), .sdaOe(sSdaOe));
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic chkIrq(input logic e);
    repeat (2) @(posedge clk);
    #1 chk("irq", {7'h0, e}, {7'h0, irq});
  endtask : chkIrq
  // bounded wait for the busy flag to drop
  task automatic idle;
    logic [7:0] s;
    repeat (20) @(posedge clk);
    for (int i = 0; i < 400; i++) begin
      rd(`I2M_A_STAT, s);
      if (s[7] === 1'b0) return;
      repeat (8) @(posedge clk);
    end
    fails++;
    print_verdict();
  endtask : idle
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {rst_b, regWr, regRd, regAddr, regWdata, slow, fails, checks} = '0;
    ackOn = 1'b1;
    rdBase = 8'hc0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd(`I2M_A_STAT, v); chk("stat reset", 8'h00, v);
    rd(`I2M_A_MASK, v); chk("mask reset", 8'h00, v);
    wr(3'h7, 8'hff); rd(3'h7, v); chk("unmapped", 8'h00, v);
    chkIrq(1'b0);
    wr(`I2M_A_CFG, 8'h80);
    wr(`I2M_A_MASK, 8'h51);
    rd(`I2M_A_CFG, v); chk("cfg", 8'h80, v);
    @(posedge clk);
    #1 chk("rdata idle", 8'h00, regRdata);
    // write of four bytes, fifth load overflows
    for (int i = 0; i < 5; i++) wr(`I2M_A_TXD, 8'ha1 + 8'(i));
    rd(`I2M_A_STAT, v); chk("stat full ovf", 8'h0d, v);
    chkIrq(1'b1);
    wr(`I2M_A_STAT, 8'h01);
    n0 = u_slave.nGot;
    p0 = u_slave.nStop;
    wr(`I2M_A_ADR, 8'h50);
    idle();
    chk("addr byte", 8'h50, u_slave.got[n0]);
    for (int i = 1; i < 5; i++) chk("tx order", 8'ha0 + 8'(i), u_slave.got[n0+i]);
    chk("tx bytes", 8'h05, 8'(u_slave.nGot - n0));
    chk("stops", 8'h01, 8'(u_slave.nStop - p0));
    chk("pads free", 8'h00, {4'h0, sclO, sdaO, sclOe, sdaOe});
    rd(`I2M_A_STAT, v); chk("stat tx empty", 8'h10, v);
    chkIrq(1'b1);
    wr(`I2M_A_STAT, 8'h10);
    chkIrq(1'b0);
    // slave refuses the address
    ackOn <= 1'b0;
    wr(`I2M_A_TXD, 8'hb1);
    wr(`I2M_A_TXD, 8'hb2);
    rd(`I2M_A_STAT, v); chk("stat partial", 8'h08, v);
    n0 = u_slave.nGot;
    p0 = u_slave.nStop;
    wr(`I2M_A_ADR, 8'h52);
    idle();
    rd(`I2M_A_STAT, v); chk("stat nack", 8'h50, v);
    rd(`I2M_A_ADR, v); chk("adr", 8'h52, v);
    chk("nack bytes", 8'h01, 8'(u_slave.nGot - n0));
    chk("nack stop", 8'h01, 8'(u_slave.nStop - p0));
    chkIrq(1'b1);
    wr(`I2M_A_STAT, 8'h50);
    chkIrq(1'b0);
    ackOn <= 1'b1;
    // reads: per-byte flag, full-only flag below and at full
    wr(`I2M_A_MASK, 8'h20);
    for (int k = 0; k < 3; k++) begin
      cn = (k == 2) ? 8'h04 : 8'h03;
      md = (k != 0);
      wr(`I2M_A_MODE, {7'h0, md});
      // second pass runs at the next slower bit rate
      wr(`I2M_A_CFG, 8'h80 | cn | ((k == 1) ? 8'h20 : 8'h00));
      a0 = u_slave.nAck;
      wr(`I2M_A_ADR, 8'h51);
      idle();
      rd(`I2M_A_STAT, v); chk("rx flag", {7'h0, !md || cn == 8'h04}, {7'h0, v[5]});
      chkIrq(!md || cn == 8'h04);
      chk("rx bytes", cn, 8'(u_slave.nAck - a0));
      for (int i = 0; i < cn; i++) begin
        chk("master ack", {7'h0, i == cn - 1}, {7'h0, u_slave.acks[a0+i]});
        rd(`I2M_A_RXD, v); chk("rx data", rdBase + 8'(a0 + i), v);
      end
      chkIrq(1'b0);
    end
    // address rewritten mid-write, slow slave
    slow <= 1'b1;
    wr(`I2M_A_CFG, 8'h81);
    wr(`I2M_A_TXD, 8'hd5);
    s0 = u_slave.nStart;
    p0 = u_slave.nStop;
    n0 = u_slave.nGot;
    a0 = u_slave.nAck;
    wr(`I2M_A_ADR, 8'h54);
    repeat (40) @(posedge clk);
    wr(`I2M_A_ADR, 8'h55);
    idle();
    chk("starts", 8'h02, 8'(u_slave.nStart - s0));
    chk("one stop", 8'h01, 8'(u_slave.nStop - p0));
    chk("first data", 8'hd5, u_slave.got[n0+1]);
    chk("second addr", 8'h55, u_slave.got[n0+2]);
    chk("read one", 8'h01, 8'(u_slave.nAck - a0));
    rd(`I2M_A_RXD, v); chk("rx after rs", rdBase + 8'(a0), v);
    print_verdict();
  end
endmodule : i2m_master_tb
